// [dv/sads_afe_model.sv]
// Purpose: Behavioural sample/hold and comparator.
// Assumes: level_i holds one byte per channel, channel 0 lowest.
// Notes:   Comparator settles settle_ns after a tap move.
`timescale 1ns/100ps

module sads_afe_model #(
    parameter integer settle_ns = 3
) (
    input wire clk_i,
    input wire sample_i,
    input wire [2:0] channel_i,
    input wire [7:0] tap_code_i,
    input wire [63:0] level_i,
    output wire above_o
);
    reg [7:0] held_r = 8'h00;

    // Track the pin while sampling, then hold it.
    always @(posedge clk_i) begin
        if (sample_i) begin
            held_r <= level_i[channel_i * 8 +: 8];
        end
    end

    // Equal counts as above, so a finished code equals the held level.
    assign #(settle_ns) above_o = (held_r >= tap_code_i);
endmodule // sads_afe_model

// [dv/sads_props.sv]
// Purpose: Port-level properties of the sequencer.
// Assumes: Code 001 gives 16 sample clocks and 8-clock steps.
// Notes:   Helpers mirror the mode register.
`timescale 1ns/100ps

module sads_props (
    input wire clk_i,
    input wire reset_i,
    input wire wr_i,
    input wire [1:0] wr_addr_i,
    input wire [7:0] wr_data_i,
    input wire bit_wr_i,
    input wire [2:0] bit_sel_i,
    input wire bit_val_i,
    input wire external_trigger_input_i,
    input wire sample_o,
    input wire [7:0] tap_code_o,
    input wire [2:0] channel_select_field_o,
    input wire ref_switch_closed_o,
    input wire busy_o,
    input wire conversion_done_irq_o
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    reg [7:0] mode_r;
    reg [3:0] trig_age_r;
    reg trig_q_r;
    reg [7:0] tap_q_r;
    wire mode_wr = wr_i && (wr_addr_i == 2'h0);
    wire [7:0] low_bit = tap_q_r & (~tap_q_r + 8'h01);

    // Mode copy, trigger rise age and last tap.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mode_r <= 8'h01;
            trig_age_r <= 4'hf;
            trig_q_r <= 1'b0;
            tap_q_r <= 8'h00;
        end else begin
            trig_q_r <= external_trigger_input_i;
            tap_q_r <= tap_code_o;
            if (mode_wr) begin
                mode_r <= wr_data_i;
            end else if (bit_wr_i) begin
                mode_r[bit_sel_i] <= bit_val_i;
            end
            if (external_trigger_input_i && !trig_q_r) begin
                trig_age_r <= 4'h0;
            end else if (trig_age_r != 4'hf) begin
                trig_age_r <= trig_age_r + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    property p_reset_state;
        disable iff (1'b0) reset_i |-> ref_switch_closed_o && !busy_o &&
            (channel_select_field_o == 3'h0);
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("reset state wrong");

    property p_refcut;
        wr_i && (wr_addr_i == 2'h2) |=>
            (ref_switch_closed_o != $past(wr_data_i[0]));
    endproperty
    a_refcut: assert property (p_refcut) else $error("ref switch wrong");

    property p_sw_start;
        mode_wr && (wr_data_i[7:6] == 2'b10) |=> sample_o && busy_o;
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("no restart");

    property p_halt;
        mode_wr && !wr_data_i[7] |=> !busy_o && !conversion_done_irq_o;
    endproperty
    a_halt: assert property (p_halt) else $error("no halt");

    property p_trg_wait;
        mode_wr && (wr_data_i[7:6] == 2'b11) |=> !busy_o;
    endproperty
    a_trg_wait: assert property (p_trg_wait) else $error("no wait");

    property p_hw_start;
        $rose(busy_o) && mode_r[6] |->
            (trig_age_r >= 4'h1) && (trig_age_r <= 4'h5);
    endproperty
    a_hw_start: assert property (p_hw_start) else $error("bad start");

    property p_sw_repeat;
        conversion_done_irq_o && !mode_r[6] && !mode_wr && !bit_wr_i |=>
            sample_o;
    endproperty
    a_sw_repeat: assert property (p_sw_repeat) else $error("no repeat");

    property p_hw_single;
        conversion_done_irq_o && mode_r[6] && !mode_wr && !bit_wr_i |=>
            !busy_o;
    endproperty
    a_hw_single: assert property (p_hw_single) else $error("reran");

    property p_first_tap;
        $fell(sample_o) && busy_o |-> (tap_code_o == 8'h80);
    endproperty
    a_first_tap: assert property (p_first_tap) else $error("bad msb");

    property p_tap_walk;
        $changed(tap_code_o) && busy_o && !sample_o && $past(busy_o) &&
            !$past(sample_o) && (low_bit > 8'h01) |->
            ((tap_code_o | low_bit) == (tap_q_r | (low_bit >> 1)));
    endproperty
    a_tap_walk: assert property (p_tap_walk)
        else $error("bad tap step");

    property p_step_len;
        $changed(tap_code_o) && busy_o && !sample_o && !mode_wr &&
            (mode_r[5:4] == 2'b00) && mode_r[0] |=>
            ($stable(tap_code_o) || !busy_o || sample_o) [*7];
    endproperty
    a_step_len: assert property (p_step_len) else $error("short step");
endmodule // sads_props

bind sads_top sads_props u_props (.clk_i(clk_i), .reset_i(reset_i),
    .wr_i(wr_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i),
    .bit_wr_i(bit_wr_i), .bit_sel_i(bit_sel_i), .bit_val_i(bit_val_i),
    .external_trigger_input_i(external_trigger_input_i),
    .sample_o(sample_o), .tap_code_o(tap_code_o),
    .channel_select_field_o(channel_select_field_o),
    .ref_switch_closed_o(ref_switch_closed_o), .busy_o(busy_o),
    .conversion_done_irq_o(conversion_done_irq_o));

// [dv/sads_top_tb.sv]
// Purpose: Self-checking bench of the sequencer.
// Assumes: One fixed input level per channel.
// Notes:   Each scenario task judges itself.
`timescale 1ns/100ps

module sads_top_tb;
    // ------------------------------------------------------------------
    // Stimulus and wiring
    // ------------------------------------------------------------------
    reg clk_i = 1'b0;
    reg reset_i = 1'b0;
    reg wr_i = 1'b0;
    reg [1:0] wr_addr_i = 2'h0;
    reg [7:0] wr_data_i = 8'h00;
    reg bit_wr_i = 1'b0;
    reg [2:0] bit_sel_i = 3'h0;
    reg bit_val_i = 1'b0;
    reg rd_i = 1'b0;
    reg [1:0] rd_addr_i = 2'h0;
    reg external_trigger_input_i = 1'b0;
    wire [7:0] rd_data_o;
    wire comp_above_i;
    wire sample_o;
    wire [7:0] tap_code_o;
    wire [2:0] channel_select_field_o;
    wire busy_o;
    wire ref_switch_closed_o;
    wire conversion_done_irq_o;
    wire [7:0] pins;
    // One level per channel: six boundary codes and two alternating patterns.
    wire [63:0] levels = 64'hfe5aa5017f8000ff;
    integer err_count = 0;
    integer checked = 0;

    // A 100 MHz clock.
    always #5 clk_i = ~clk_i;

    sads_top dut (.clk_i(clk_i), .reset_i(reset_i), .wr_i(wr_i),
        .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .bit_wr_i(bit_wr_i),
        .bit_sel_i(bit_sel_i), .bit_val_i(bit_val_i), .rd_i(rd_i),
        .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
        .external_trigger_input_i(external_trigger_input_i),
        .comp_above_i(comp_above_i), .sample_o(sample_o),
        .tap_code_o(tap_code_o), .channel_select_field_o(channel_select_field_o),
        .analog_pin_select_o(pins), .ref_switch_closed_o(ref_switch_closed_o),
        .busy_o(busy_o), .conversion_done_irq_o(conversion_done_irq_o));

    sads_afe_model #(.settle_ns(7)) u_afe (.clk_i(clk_i), .sample_i(sample_o),
        .channel_i(channel_select_field_o), .tap_code_i(tap_code_o),
        .level_i(levels), .above_o(comp_above_i));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task stop_test;
        begin
            $display("checks=%0d errors=%0d", checked, err_count);
            if (err_count == 0 && checked > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask

    task check(input [7:0] got, input [7:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task wr(input [1:0] a, input [7:0] d);
        begin
            @(posedge clk_i);
            wr_i <= 1'b1;
            wr_addr_i <= a;
            wr_data_i <= d;
            @(posedge clk_i);
            wr_i <= 1'b0;
            #1;
        end
    endtask

    task rd(input [1:0] a, output [7:0] d);
        begin
            @(posedge clk_i);
            rd_i <= 1'b1;
            rd_addr_i <= a;
            @(posedge clk_i);
            rd_i <= 1'b0;
            #1;
            d = rd_data_o;
        end
    endtask

    // Up to lim cycles; a missing expected pulse ends the run.
    task wait_irq(input integer lim, input expect_irq);
        integer n;
        reg seen;
        begin
            seen = 1'b0;
            for (n = 0; n < lim && !seen; n = n + 1) begin
                @(posedge clk_i);
                #1;
                seen = (conversion_done_irq_o === 1'b1);
            end
            check({7'h0, seen}, {7'h0, expect_irq});
            if (expect_irq && !seen) begin
                stop_test;
            end
        end
    endtask

    task trig;
        begin
            @(posedge clk_i);
            external_trigger_input_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            external_trigger_input_i <= 1'b0;
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset;
        reg [7:0] d;
        begin
            rd(2'h0, d);
            check(d, 8'h01);
            rd(2'h2, d);
            check(d, 8'h00);
            check({7'h0, ref_switch_closed_o}, 8'h01);
            wr(2'h2, 8'h01);
            check({7'h0, ref_switch_closed_o}, 8'h00);
            rd(2'h2, d);
            check(d, 8'h01);
            wr(2'h2, 8'h00);
            check({7'h0, ref_switch_closed_o}, 8'h01);
        end
    endtask

    // Each channel; every mode write after the first cuts the running cycle.
    task t_sw;
        integer i;
        reg [7:0] d;
        begin
            wr(2'h1, 8'hff);
            check(pins, 8'hff);
            for (i = 0; i < 8; i = i + 1) begin
                wr(2'h0, {2'b10, i[0], 1'b0, i[2:0], 1'b1});
                wait_irq(140, 1'b1);
                rd(2'h3, d);
                check(d, levels[i * 8 +: 8]);
            end
            wr(2'h3, 8'h33);
            wait_irq(140, 1'b1);
            rd(2'h3, d);
            check(d, levels[63:56]);
        end
    endtask

    task t_halt;
        reg [7:0] d;
        begin
            wr(2'h0, 8'h83);
            repeat (40) @(posedge clk_i);
            wr(2'h0, 8'h03);
            check({7'h0, busy_o}, 8'h00);
            wait_irq(200, 1'b0);
            @(posedge clk_i);
            bit_sel_i <= 3'h7;
            bit_val_i <= 1'b1;
            bit_wr_i <= 1'b1;
            @(posedge clk_i);
            bit_wr_i <= 1'b0;
            wait_irq(140, 1'b1);
            rd(2'h3, d);
            check(d, levels[15:8]);
        end
    endtask

    task t_hw;
        reg [7:0] d;
        begin
            wr(2'h0, 8'hc5);
            wait_irq(60, 1'b0);
            check({7'h0, busy_o}, 8'h00);
            trig;
            wait_irq(140, 1'b1);
            rd(2'h3, d);
            check(d, levels[23:16]);
            wait_irq(150, 1'b0);
            trig;
            repeat (10) @(posedge clk_i);
            wr(2'h0, 8'hc7);
            wait_irq(150, 1'b0);
            trig;
            wait_irq(140, 1'b1);
            rd(2'h3, d);
            check(d, levels[31:24]);
            trig;
            repeat (30) @(posedge clk_i);
            wr(2'h0, 8'h47);
            check({7'h0, busy_o}, 8'h00);
            wait_irq(150, 1'b0);
        end
    endtask

    // Reset for six clocks, then run the scenarios.
    initial begin
        reset_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset;
        t_sw;
        t_halt;
        t_hw;
        stop_test;
    end
endmodule // sads_top_tb

// [logic/sads_regs.vh]
// Purpose: Constants of the converter sequencer.
// Assumes: Included by the sequencer top module by bare name.
// Notes:   Offsets, field positions, reset values and cycle counts only.
`ifndef SADS_REGS_VH
`define SADS_REGS_VH

// ----------------------------------------------------------------------
// Register indices on the register port
// ----------------------------------------------------------------------
`define SADS_ADDR_MODE 2'h0
`define SADS_ADDR_PINSEL 2'h1
`define SADS_ADDR_REFCUT 2'h2
`define SADS_ADDR_RESULT 2'h3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SADS_MODE_RST 8'h01
`define SADS_PINSEL_RST 8'h00
`define SADS_REFCUT_RST 8'h00

// ----------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------
`define SADS_MODE_SPEED 0
`define SADS_MODE_CH_LO 1
`define SADS_MODE_CH_HI 3
`define SADS_MODE_TLO 4
`define SADS_MODE_THI 5
`define SADS_MODE_TRG 6
`define SADS_MODE_RUN 7

// Reference cut: bit 0 set opens the internal switch.
`define SADS_REFCUT_OPEN 0

// ----------------------------------------------------------------------
// Conversion time codes {hi, lo, speed} and their lengths in clocks
// ----------------------------------------------------------------------
`define SADS_TCODE_80 3'h1
`define SADS_TCODE_40 3'h3
`define SADS_TCODE_50 3'h4
`define SADS_TCODE_100 3'h5
`define SADS_TIME_80 7'd80
`define SADS_TIME_40 7'd40
`define SADS_TIME_50 7'd50
`define SADS_TIME_100 7'd100
// Sampling takes one fifth of the time, each bit one tenth.
`define SADS_SAMPLE_DIV 7'd5
`define SADS_STEP_DIV 7'd10

`endif

// [logic/sads_sar.v]
// Purpose: Approximation shift register of the converter.
// Assumes: start_i and decide_i never coincide.
// Notes:   The register value is the tap code offered to the comparator.
`timescale 1ns/100ps

module sads_sar (
    input wire clk_i,
    input wire reset_i,
    input wire start_i,
    input wire decide_i,
    input wire above_i,
    output reg [7:0] trial_o,
    output wire last_o
);

    reg [7:0] mask_r;

    // The mask marks the bit on trial; it walks down from the top bit.
    assign last_o = mask_r[0];

    // A trial bit stays set only when the input lies above the tap, and
    // the next lower bit is set at once, so the tap for the following
    // step is built from the bits already decided.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            trial_o <= 8'h00;
            mask_r <= 8'h00;
        end else if (start_i) begin
            trial_o <= 8'h80; // RULE5
            mask_r <= 8'h80;
        end else if (decide_i) begin
            trial_o <= (above_i ? trial_o : (trial_o & ~mask_r)) // RULE6
                | (mask_r >> 1); // RULE7
            mask_r <= mask_r >> 1; // RULE8
        end
    end

endmodule // sads_sar

// [logic/sads_sync.v]
// Purpose: Two-stage synchroniser for inputs from outside the clock.
// Assumes: Inputs are levels that stay put for several clocks.
// Notes:   The first stage is read by the second stage only.
`timescale 1ns/100ps

module sads_sync #(
    parameter W = 1
) (
    input wire clk_i,
    input wire reset_i,
    input wire [W-1:0] async_i,
    output reg [W-1:0] sync_o
);

    reg [W-1:0] meta_r;

    // Two flops settle any metastable sample before logic sees it.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_r <= {W{1'b0}};
            sync_o <= {W{1'b0}};
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule // sads_sync

// [logic/sads_top.v]
// Purpose: Sequencer of an 8-bit successive-approximation converter.
// Assumes: Sample/hold, comparator and tap string are outside.
// Notes:   One clock, the main system clock; no extra bus is added.
//
// Notes on behaviour
// [RULE1] Reference cut register resets to zero.
// [RULE2] Zero connects supply to reference; one opens.
// [RULE3] Software writes reference cut as whole bytes.
// [RULE4] Software picks analog pins before the channel.
// [RULE5] Hold starts: set top bit, half tap.
// [RULE6] Keep bit if input above tap, else clear.
// [RULE7] Next bit set; tap follows decided bits.
// [RULE8] Repeat down to the lowest bit.
// [RULE9] After eight steps copy result, raise done.
// [RULE10] Result store and done request coincide.
// [RULE11] Conversions continue until run bit cleared.
// [RULE12] Mode write aborts; run one restarts sequence.
// [RULE13] Result register has no reset value.
// [RULE14] Trigger mode waits for external trigger edge.
// [RULE15] Trigger mode: one conversion per trigger.
// [RULE16] Trigger mode rewrite: abandon, await new trigger.
// [RULE17] Run bit written zero halts, no result.
// [RULE18] Software mode starts directly on the write.
// [RULE19] Software mode repeats conversions back to back.
// [RULE20] Software mode rewrite restarts with new settings.
// [RULE21] Stops whenever the main clock stops.
// [RULE22] Mode resets to one; channel, trigger, run.
// [RULE23] Software avoids conversion times below the minimum.
// [RULE24] Software clears done flag before restarting.
// [RULE25] Time split: sampling, eight steps, transfer.
`timescale 1ns/100ps

`include "sads_regs.vh"

module sads_top (
    input wire clk_i,
    input wire reset_i,
    // Register port of the memory manipulation instructions.
    input wire wr_i,
    input wire [1:0] wr_addr_i,
    input wire [7:0] wr_data_i,
    input wire bit_wr_i,
    input wire [2:0] bit_sel_i,
    input wire bit_val_i,
    input wire rd_i,
    input wire [1:0] rd_addr_i,
    output reg [7:0] rd_data_o,
    // Trigger pin and analog front end.
    input wire external_trigger_input_i,
    input wire comp_above_i,
    output wire sample_o,
    output wire [7:0] tap_code_o,
    output wire [2:0] channel_select_field_o,
    output wire [7:0] analog_pin_select_o,
    output wire ref_switch_closed_o,
    output wire busy_o,
    output reg conversion_done_irq_o
);

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_WAIT = 2'b01;
    localparam ST_SAMPLE = 2'b10;
    localparam ST_CONV = 2'b11;

    reg [7:0] conversion_mode_reg_r;
    reg [7:0] analog_pin_select_reg_r;
    reg [7:0] reference_current_cut_select_r;
    reg [7:0] conversion_result_reg_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [6:0] cnt_r;
    reg [6:0] cnt_nxt;
    reg [7:0] mode_nxt;
    reg trig_d_r;
    reg sar_start;
    reg sar_decide;
    reg store;
    wire mode_wr;
    wire [6:0] conv_time;
    wire [6:0] sample_len;
    wire [6:0] step_len;
    wire trig_sync;
    wire above_sync;
    wire trig_edge;
    wire sar_last;
    wire [7:0] trial;
    wire run_bit;
    wire trg_bit;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Total conversion time in clocks for a {hi, lo, speed} code.
    // Prohibited codes take the longest time, which is always safe for
    // the analog side; software must still not pick them.
    function [6:0] conv_cycles;
        input [2:0] code;
        begin
            case (code)
                `SADS_TCODE_80: conv_cycles = `SADS_TIME_80;
                `SADS_TCODE_40: conv_cycles = `SADS_TIME_40;
                `SADS_TCODE_50: conv_cycles = `SADS_TIME_50;
                `SADS_TCODE_100: conv_cycles = `SADS_TIME_100;
                default: conv_cycles = `SADS_TIME_100;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------

    // The trigger pin and the comparator come from outside the clock.
    sads_sync #(
        .W(2)
    ) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i({external_trigger_input_i, comp_above_i}),
        .sync_o({trig_sync, above_sync})
    );

    // Rising edge of the synchronised trigger; a held level fires once.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            trig_d_r <= 1'b0;
        end else begin
            trig_d_r <= trig_sync;
        end
    end

    assign trig_edge = trig_sync & ~trig_d_r;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------

    // A byte write or a single-bit write both count as a mode write.
    assign mode_wr = (wr_i & (wr_addr_i == `SADS_ADDR_MODE)) | bit_wr_i;

    // Next mode value; a bit write changes only the addressed bit.
    always @* begin
        mode_nxt = conversion_mode_reg_r;
        if (wr_i && (wr_addr_i == `SADS_ADDR_MODE)) begin
            mode_nxt = wr_data_i;
        end else if (bit_wr_i) begin
            mode_nxt[bit_sel_i] = bit_val_i;
        end
    end

    // Control registers. Only the mode register takes bit writes; the
    // pin select and reference cut registers are byte-only.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            conversion_mode_reg_r <= `SADS_MODE_RST; // RULE22
            analog_pin_select_reg_r <= `SADS_PINSEL_RST;
            reference_current_cut_select_r <= `SADS_REFCUT_RST; // RULE1
        end else begin
            conversion_mode_reg_r <= mode_nxt;
            if (wr_i && (wr_addr_i == `SADS_ADDR_PINSEL)) begin
                analog_pin_select_reg_r <= wr_data_i;
            end
            if (wr_i && (wr_addr_i == `SADS_ADDR_REFCUT)) begin
                reference_current_cut_select_r <= wr_data_i; // RULE3
            end
        end
    end

    // Bit 0 of the reference cut opens the internal switch for standby.
    assign ref_switch_closed_o =
        ~reference_current_cut_select_r[`SADS_REFCUT_OPEN]; // RULE2

    assign analog_pin_select_o = analog_pin_select_reg_r;
    assign channel_select_field_o =
        conversion_mode_reg_r[`SADS_MODE_CH_HI:`SADS_MODE_CH_LO];
    assign run_bit = conversion_mode_reg_r[`SADS_MODE_RUN];
    assign trg_bit = conversion_mode_reg_r[`SADS_MODE_TRG];

    // ------------------------------------------------------------------
    // Timing of one conversion
    // ------------------------------------------------------------------

    // The settings in force are those of the last mode write, because
    // any mode write aborts the sequence before they could be used.
    assign conv_time = conv_cycles({
        conversion_mode_reg_r[`SADS_MODE_THI],
        conversion_mode_reg_r[`SADS_MODE_TLO],
        conversion_mode_reg_r[`SADS_MODE_SPEED]});
    assign sample_len = conv_time / `SADS_SAMPLE_DIV; // RULE25
    assign step_len = conv_time / `SADS_STEP_DIV; // RULE25

    // ------------------------------------------------------------------
    // Approximation register
    // ------------------------------------------------------------------
    sads_sar u_sar (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .start_i(sar_start),
        .decide_i(sar_decide),
        .above_i(above_sync),
        .trial_o(trial),
        .last_o(sar_last)
    );

    assign tap_code_o = trial;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------

    // Mode writes take priority over every other event, so an abort in
    // the cycle that would finish a conversion drops that result.
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sar_start = 1'b0;
        sar_decide = 1'b0;
        store = 1'b0;
        if (mode_wr) begin
            // RULE12
            cnt_nxt = 7'd0;
            if (!mode_nxt[`SADS_MODE_RUN]) begin
                state_nxt = ST_IDLE; // RULE17
            end else if (mode_nxt[`SADS_MODE_TRG]) begin
                state_nxt = ST_WAIT; // RULE14 RULE16
            end else begin
                state_nxt = ST_SAMPLE; // RULE18 RULE20
                cnt_nxt = conv_cycles({mode_nxt[`SADS_MODE_THI],
                    mode_nxt[`SADS_MODE_TLO],
                    mode_nxt[`SADS_MODE_SPEED]}) / `SADS_SAMPLE_DIV
                    - 7'd1;
            end
        end else begin
            case (state_r)
                ST_IDLE: begin
                    state_nxt = ST_IDLE;
                end
                ST_WAIT: begin
                    if (trig_edge) begin
                        state_nxt = ST_SAMPLE; // RULE14
                        cnt_nxt = sample_len - 7'd1;
                    end
                end
                ST_SAMPLE: begin
                    if (cnt_r == 7'd0) begin
                        state_nxt = ST_CONV;
                        sar_start = 1'b1; // RULE5
                        cnt_nxt = step_len - 7'd1;
                    end else begin
                        cnt_nxt = cnt_r - 7'd1;
                    end
                end
                ST_CONV: begin
                    if (cnt_r != 7'd0) begin
                        cnt_nxt = cnt_r - 7'd1;
                    end else if (!sar_last) begin
                        sar_decide = 1'b1; // RULE8
                        cnt_nxt = step_len - 7'd1;
                    end else begin
                        sar_decide = 1'b1;
                        store = 1'b1; // RULE9
                        if (trg_bit) begin
                            state_nxt = ST_WAIT; // RULE15
                        end else begin
                            state_nxt = ST_SAMPLE; // RULE11 RULE19
                            cnt_nxt = sample_len - 7'd1;
                        end
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // State and step counter; the logic runs only while the main clock
    // runs, so a stopped clock freezes the sequence where it stands.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= ST_IDLE;
            cnt_r <= 7'd0;
            conversion_done_irq_o <= 1'b0;
        end else begin
            state_r <= state_nxt; // RULE21
            cnt_r <= cnt_nxt;
            conversion_done_irq_o <= store; // RULE10
        end
    end

    // The result register is left without reset on purpose; the decided
    // lowest bit is merged in the same cycle as the transfer.
    always @(posedge clk_i) begin
        if (store) begin
            conversion_result_reg_r <= (above_sync ? trial
                : (trial & 8'hfe)); // RULE9 RULE13
        end
    end

    assign sample_o = (state_r == ST_SAMPLE);
    assign busy_o = (state_r == ST_SAMPLE) | (state_r == ST_CONV);

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------

    // Read data is registered and appears one clock after rd_i.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_i) begin
            case (rd_addr_i)
                `SADS_ADDR_MODE: rd_data_o <= conversion_mode_reg_r;
                `SADS_ADDR_PINSEL: rd_data_o <= analog_pin_select_reg_r;
                `SADS_ADDR_REFCUT: begin
                    rd_data_o <= reference_current_cut_select_r;
                end
                `SADS_ADDR_RESULT: rd_data_o <= conversion_result_reg_r;
                default: rd_data_o <= 8'h00;
            endcase
        end
    end

endmodule // sads_top
